// ### bench/lhcr_phy_model.sv
// Far-side stand-in: gated PHY clock and addressed-packet strobe
`timescale 1ns/100ps
`default_nettype none

module lhcr_phy_model (
  input  wire logic core_clk_i,
  input  wire logic run_i,
  input  wire logic send_i,
  output var  logic link_clk_o,
  output var  logic async_req_o
);
  // Holds its level while stopped; phase unrelated to the core clock
  initial begin
    link_clk_o = 1'b0;
    #7;
    forever begin
      #32;
      if (run_i) begin
        link_clk_o = ~link_clk_o;
      end
    end
  end
  // This node is never bus manager, so tardy answers are allowed
  always_ff @(posedge core_clk_i) begin
    async_req_o <= send_i;
  end
endmodule
`default_nettype wire

// ### bench/lhcr_properties.sv
// Port-level checker for the link host control bank
`timescale 1ns/100ps
`default_nettype none

module lhcr_properties
  import lhcr_pkg::*;
#(
  parameter int STOP_CYC = 40,
  parameter int SWR_LEN  = 4
) (
  input wire logic        CORE_CLK_I,
  input wire logic        RESET_N_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        ASYNC_REQ_I,
  input wire logic        ACK_TARDY_O,
  input wire logic        NO_BYTE_SWAP_O,
  input wire logic        PHY_ENHANCE_O,
  input wire logic        LINK_POWER_O,
  input wire logic        POSTED_WRITE_O,
  input wire logic        LINK_ON_O,
  input wire logic        SOFT_RESET_O,
  input wire logic        LINK_CLK_STOPPED_O,
  input wire logic [31:0] SELF_ID_BASE_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  int swr_cnt_q;
  wire ctl_a = PADDR_I inside {OFS_CTRL_SET, OFS_CTRL_CLR};
  wire ctl_rd = PREADY_O && !PWRITE_I && !PSLVERR_O && ctl_a;
  wire phy_a = (PADDR_I >= OFS_PHY_A_LO && PADDR_I <= OFS_PHY_A_HI)
            || (PADDR_I >= OFS_PHY_B_LO && PADDR_I <= OFS_PHY_B_HI);
  // Bit 16 is left out: it may fall on the very edge of the read
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      swr_cnt_q <= 0;
    end else if (SOFT_RESET_O) begin
      swr_cnt_q <= swr_cnt_q + 1;
    end else begin
      swr_cnt_q <= 0;
    end
  end
  sequence s_setup;
    PSEL_I && !PENABLE_I && (ctl_a || PADDR_I == OFS_SELF_ID);
  endsequence
  sequence s_access;
    PSEL_I && PENABLE_I;
  endsequence
  ready_wait_a: assert property (s_setup ##1 s_access |=> PREADY_O)
    else $error("register access not answered after one wait");
  ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held longer than one cycle");
  rsvd_zero_a: assert property (ctl_rd |-> !(|(PRDATA_O & 32'h1f30ffff)))
    else $error("reserved control bits read nonzero");
  ctl_mirror_a: assert property (ctl_rd |-> PRDATA_O[30] == NO_BYTE_SWAP_O
    && PRDATA_O[22] == PHY_ENHANCE_O && PRDATA_O[19] == LINK_POWER_O
    && PRDATA_O[18] == POSTED_WRITE_O && PRDATA_O[17] == LINK_ON_O)
    else $error("control read differs from control outputs");
  ack_cause_a: assert property (ACK_TARDY_O |->
    $past(ASYNC_REQ_I && LINK_ON_O && !SOFT_RESET_O))
    else $error("tardy ack without request on an enabled link");
  enh_gate_a: assert property ($rose(PHY_ENHANCE_O) |-> $past(LINK_ON_O))
    else $error("enhancements enabled while link off");
  posted_lock_a: assert property (LINK_ON_O && $past(LINK_ON_O)
    |-> $stable(POSTED_WRITE_O))
    else $error("posted write bit changed while link on");
  swr_len_a: assert property ($fell(SOFT_RESET_O) |-> swr_cnt_q == SWR_LEN)
    else $error("soft reset length wrong");
  swr_clear_a: assert property (SOFT_RESET_O && $past(SOFT_RESET_O) |->
    !(LINK_ON_O || LINK_POWER_O || PHY_ENHANCE_O || POSTED_WRITE_O
    || NO_BYTE_SWAP_O) && SELF_ID_BASE_O == 32'h0)
    else $error("control state kept during soft reset");
  sid_align_a: assert property (SELF_ID_BASE_O[10:0] == 11'h000)
    else $error("self-ID base not 2K aligned");
  stop_abort_a: assert property (PREADY_O && !PWRITE_I && phy_a
    && LINK_CLK_STOPPED_O |-> PSLVERR_O || PRDATA_O == RD_ALL_ONES)
    else $error("stopped link clock read neither aborted nor all ones");
endmodule

bind lhcr_top lhcr_properties #(.STOP_CYC(STOP_CYC), .SWR_LEN(SWR_LEN)) chk_u (
  .CORE_CLK_I, .RESET_N_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I,
  .PRDATA_O, .PREADY_O, .PSLVERR_O, .ASYNC_REQ_I, .ACK_TARDY_O,
  .NO_BYTE_SWAP_O, .PHY_ENHANCE_O, .LINK_POWER_O, .POSTED_WRITE_O,
  .LINK_ON_O, .SOFT_RESET_O, .LINK_CLK_STOPPED_O, .SELF_ID_BASE_O);
`default_nettype wire

// ### bench/link_host_control_regs_test.sv
// Self-checking bench for the link host control bank
`timescale 1ns/100ps
`default_nettype none

module link_host_control_regs_test;
  import lhcr_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdat = 32'h0;
  logic        ld = 1'b0;
  logic        perm = 1'b0;
  logic        run = 1'b0;
  logic        send = 1'b0;
  logic [31:0] prdata, sid, rd;
  logic        pready, pslverr, lclk, areq, ack, er;
  logic        nbs, enh, link_power_on, pw, lon, swr, stopped;
  int          miscompares = 0;
  int          n_compared = 0;

  always #2 clk = ~clk;

  lhcr_phy_model phy_u (.core_clk_i(clk), .run_i(run), .send_i(send),
    .link_clk_o(lclk), .async_req_o(areq));
  lhcr_top #(.STOP_CYC(40), .SWR_LEN(8)) dut_u (
    .CORE_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(addr), .PWDATA_I(wdat), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .LINK_CLK_I(lclk),
    .EEPROM_LOAD_I(ld), .EEPROM_PERMIT_I(perm), .ASYNC_REQ_I(areq),
    .ACK_TARDY_O(ack), .NO_BYTE_SWAP_O(nbs), .PHY_ENHANCE_O(enh),
    .LINK_POWER_O(link_power_on), .POSTED_WRITE_O(pw), .LINK_ON_O(lon),
    .SOFT_RESET_O(swr), .LINK_CLK_STOPPED_O(stopped), .SELF_ID_BASE_O(sid));

  // ****************************
  // Shared bus and compare tasks
  // ****************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Request held until the edge that samples ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wdat <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
    end
    chk(32'(n < 100), 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
    chk({31'h0, er}, {31'h0, ee});
  endtask
  task automatic eeprom(input logic v);
    @(posedge clk);
    ld <= 1'b1;
    perm <= v;
    @(posedge clk);
    ld <= 1'b0;
  endtask
  task automatic tardy(input int exp_n);
    int n;
    n = 0;
    @(posedge clk);
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    repeat (6) begin
      @(negedge clk);
      if (ack === 1'b1) n++;
    end
    chk(32'(n), 32'(exp_n));
  endtask

  // ****************************
  // Scenarios
  // ****************************
  task automatic t_reset();
    rdc(OFS_CTRL_SET, 32'h0080_0000, 1'b0);
    rdc(OFS_CTRL_CLR, 32'h0080_0000, 1'b0);
  endtask
  task automatic t_setclr();
    wr(OFS_CTRL_SET, 32'h000a_0000);
    wr(OFS_CTRL_SET, 32'h7ffe_ffff);
    rdc(OFS_CTRL_SET, 32'h60ca_0000, 1'b0);
    rdc(OFS_CTRL_CLR, 32'h60ca_0000, 1'b0);
    chk({27'h0, nbs, enh, link_power_on, pw, lon}, 32'h1d);
    wr(OFS_CTRL_CLR, 32'h0080_0000);
    wr(OFS_CTRL_CLR, 32'h0002_0000);
    wr(OFS_CTRL_SET, 32'h0004_0000);
    rdc(OFS_CTRL_SET, 32'h60cc_0000, 1'b0);
  endtask
  task automatic t_enh();
    wr(OFS_CTRL_CLR, 32'h0040_0000);
    wr(OFS_CTRL_SET, 32'h0040_0000);
    rdc(OFS_CTRL_SET, 32'h608c_0000, 1'b0);
    eeprom(1'b0);
    wr(OFS_CTRL_SET, 32'h0002_0000);
    wr(OFS_CTRL_SET, 32'h0040_0000);
    rdc(OFS_CTRL_SET, 32'h600e_0000, 1'b0);
    eeprom(1'b1);
    wr(OFS_CTRL_SET, 32'h0040_0000);
    rdc(OFS_CTRL_SET, 32'h60ce_0000, 1'b0);
  endtask
  task automatic t_tardy();
    tardy(1);
    rdc(OFS_EVENT_SET, 32'h0800_0000, 1'b0);
    wr(OFS_EVENT_CLR, 32'h0800_0000);
    rdc(OFS_EVENT_CLR, 32'h0, 1'b0);
    wr(OFS_CTRL_CLR, 32'h0002_0000);
    tardy(0);
    wr(OFS_CTRL_SET, 32'h0002_0000);
    wr(OFS_CTRL_CLR, 32'h2000_0000);
    tardy(0);
    rdc(OFS_EVENT_SET, 32'h0, 1'b0);
  endtask
  task automatic t_sid();
    wr(OFS_SELF_ID, 32'hffff_ffff);
    rdc(OFS_SELF_ID, 32'hffff_f800, 1'b0);
    chk(sid, 32'hffff_f800);
    rdc(12'h058, 32'h0, 1'b1);
  endtask
  task automatic t_phy();
    int n;
    n = 0;
    chk({31'h0, stopped}, 32'h1);
    rdc(OFS_PHY_A_LO, 32'h0, 1'b1);
    wr(OFS_MISC_CFG, 32'h0000_0010);
    rdc(OFS_PHY_B_HI, RD_ALL_ONES, 1'b0);
    wr(OFS_PHY_B_HI, 32'h0000_0001);
    @(posedge clk);
    run <= 1'b1;
    while (stopped !== 1'b0 && n < 100) begin
      n++;
      @(posedge clk);
    end
    chk({31'h0, stopped}, 32'h0);
    rdc(OFS_PHY_B_HI, 32'h0, 1'b0);
    wr(OFS_PHY_B_LO, 32'h5a5a_a5a5);
    rdc(OFS_PHY_B_LO, 32'h5a5a_a5a5, 1'b0);
    wr(OFS_PHY_A_HI, 32'h0123_4567);
    rdc(OFS_PHY_A_HI, 32'h0123_4567, 1'b0);
  endtask
  task automatic t_swr();
    int n;
    n = 0;
    wr(OFS_CTRL_SET, 32'h0001_0000);
    apb(1'b0, OFS_CTRL_CLR, 32'h0);
    chk(rd, 32'h0081_0000);
    chk({31'h0, swr}, 32'h1);
    while (rd[BIT_SW_RESET] === 1'b1 && n < 20) begin
      n++;
      apb(1'b0, OFS_CTRL_SET, 32'h0);
    end
    chk(rd, 32'h0080_0000);
    chk({31'h0, swr}, 32'h0);
    rdc(OFS_SELF_ID, 32'h0, 1'b0);
    rdc(OFS_MISC_CFG, 32'h0000_0010, 1'b0);
    rdc(OFS_PHY_B_LO, 32'h0, 1'b0);
  endtask

  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Whole run needs well under this span
  initial begin
    #200000;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_setclr();
    t_enh();
    t_tardy();
    t_sid();
    t_phy();
    t_swr();
    conclude();
  end
endmodule
`default_nettype wire

// ### logic/lhcr_pkg.sv
// Package: offsets, fields, reset values and timing for the link control bank
package lhcr_pkg;

  // ******************************************************************
  // Register offsets (byte addresses)
  // ******************************************************************
  localparam logic [11:0] OFS_CTRL_SET   = 12'h050;
  localparam logic [11:0] OFS_CTRL_CLR   = 12'h054;
  localparam logic [11:0] OFS_SELF_ID    = 12'h064;
  localparam logic [11:0] OFS_EVENT_SET  = 12'h080;
  localparam logic [11:0] OFS_EVENT_CLR  = 12'h084;
  localparam logic [11:0] OFS_MISC_CFG   = 12'h1f0;
  localparam logic [11:0] OFS_PHY_A_LO   = 12'h0dc;
  localparam logic [11:0] OFS_PHY_A_HI   = 12'h0f0;
  localparam logic [11:0] OFS_PHY_B_LO   = 12'h100;
  localparam logic [11:0] OFS_PHY_B_HI   = 12'h11c;
  localparam int          PHY_A_WORDS    = 6;
  localparam int          PHY_WORDS      = 14;

  // ******************************************************************
  // Field positions
  // ******************************************************************
  localparam int BIT_NO_SWAP     = 30;
  localparam int BIT_TARDY_EN    = 29;
  localparam int BIT_PROG_PERMIT = 23;
  localparam int BIT_PHY_ENH     = 22;
  localparam int BIT_LINK_POWER  = 19;
  localparam int BIT_POSTED_WR   = 18;
  localparam int BIT_LINK_ON     = 17;
  localparam int BIT_SW_RESET    = 16;
  localparam int BIT_EV_TARDY    = 27;
  localparam int BIT_ABORT_DIS   = 4;
  localparam int SELF_ID_LSB     = 11;

  // ******************************************************************
  // Reset values
  // ******************************************************************
  localparam logic        RST_CTRL_BIT   = 1'b0;
  localparam logic        RST_PERMIT     = 1'b1;
  localparam logic [20:0] RST_SELF_ID    = 21'h00000;
  localparam logic [31:0] RD_ALL_ONES    = 32'hffffffff;

  // ******************************************************************
  // Timing
  // ******************************************************************
  localparam int CLK_MHZ          = 250;
  localparam int LCLK_STOP_NS     = 1000;
  localparam int LCLK_STOP_CYC    = (LCLK_STOP_NS * CLK_MHZ) / 1000;
  localparam int SWR_CYC          = 16;
  localparam int LPS_SETTLE_MS    = 10;

endpackage

// ### logic/lhcr_top.sv
// Link host control set/clear bank with self-ID pointer over APB
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module lhcr_top
  import lhcr_pkg::*;
#(
  parameter int STOP_CYC = lhcr_pkg::LCLK_STOP_CYC,
  parameter int SWR_LEN  = lhcr_pkg::SWR_CYC
) (
  input  wire logic        CORE_CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output var  logic [31:0] PRDATA_O,
  output var  logic        PREADY_O,
  output var  logic        PSLVERR_O,
  input  wire logic        LINK_CLK_I,
  input  wire logic        EEPROM_LOAD_I,
  input  wire logic        EEPROM_PERMIT_I,
  input  wire logic        ASYNC_REQ_I,
  output var  logic        ACK_TARDY_O,
  output var  logic        NO_BYTE_SWAP_O,
  output var  logic        PHY_ENHANCE_O,
  output var  logic        LINK_POWER_O,
  output var  logic        POSTED_WRITE_O,
  output var  logic        LINK_ON_O,
  output var  logic        SOFT_RESET_O,
  output var  logic        LINK_CLK_STOPPED_O,
  output var  logic [31:0] SELF_ID_BASE_O
);
  import lhcr_pkg::*;

  // ******************************************************************
  // State
  // ******************************************************************
  logic        no_swap_q;
  logic        tardy_en_q;
  logic        permit_q;
  logic        phy_enh_q;
  logic        link_power_q;
  logic        posted_wr_q;
  logic        link_on_q;
  logic        sw_reset_q;
  logic [7:0]  swr_cnt_q;
  logic        ev_tardy_q;
  logic        abort_dis_q;
  logic [20:0] self_id_q;
  logic        ack_tardy_q;
  logic [31:0] phy_mem_q [PHY_WORDS];
  logic        lclk_s1_q;
  logic        lclk_s2_q;
  logic        lclk_s3_q;
  logic [15:0] stop_cnt_q;
  logic        stopped_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;

  logic        lclk_rise;
  logic        access;
  logic        commit;
  logic        wr_commit;
  logic        is_phy;
  logic [3:0]  phy_idx;
  logic        mapped;
  logic        phy_ok;
  logic [31:0] ctrl_val;
  logic [31:0] rd_data;
  logic        wr_set;
  logic        wr_clr;
  logic        ev_set_hit;

  // ******************************************************************
  // Link clock sampling and stop detection
  // ******************************************************************
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      lclk_s1_q <= 1'b0;
      lclk_s2_q <= 1'b0;
      lclk_s3_q <= 1'b0;
    end else begin
      lclk_s1_q <= LINK_CLK_I;
      lclk_s2_q <= lclk_s1_q;
      lclk_s3_q <= lclk_s2_q;
    end
  end

  assign lclk_rise = lclk_s2_q & ~lclk_s3_q;

  // A clock that only halts between frames still counts as stopped
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      stop_cnt_q <= 16'h0000;
      stopped_q  <= 1'b1;
    end else if (lclk_rise) begin
      stop_cnt_q <= 16'h0000;
      stopped_q  <= 1'b0;
    end else if (stop_cnt_q >= 16'(STOP_CYC)) begin
      stopped_q  <= 1'b1;
    end else begin
      stop_cnt_q <= stop_cnt_q + 16'h0001;
    end
  end

  // ******************************************************************
  // APB decode
  // ******************************************************************
  assign access    = PSEL_I & PENABLE_I;
  assign commit    = access & pready_q;
  assign wr_commit = commit & PWRITE_I & ~pslverr_q;
  assign wr_set    = wr_commit & (PADDR_I == OFS_CTRL_SET);
  assign wr_clr    = wr_commit & (PADDR_I == OFS_CTRL_CLR);
  assign ev_set_hit = ack_tardy_q;

  always_comb begin
    is_phy  = 1'b0;
    phy_idx = 4'h0;
    if (PADDR_I[1:0] == 2'b00 && PADDR_I >= OFS_PHY_A_LO
        && PADDR_I <= OFS_PHY_A_HI) begin
      is_phy  = 1'b1;
      phy_idx = 4'((PADDR_I - OFS_PHY_A_LO) >> 2);
    end else if (PADDR_I[1:0] == 2'b00 && PADDR_I >= OFS_PHY_B_LO
        && PADDR_I <= OFS_PHY_B_HI) begin
      is_phy  = 1'b1;
      phy_idx = 4'(((PADDR_I - OFS_PHY_B_LO) >> 2) + 12'(PHY_A_WORDS));
    end
  end

  always_comb begin
    ctrl_val = 32'h00000000;
    ctrl_val[BIT_NO_SWAP]     = no_swap_q;
    ctrl_val[BIT_TARDY_EN]    = tardy_en_q;
    ctrl_val[BIT_PROG_PERMIT] = permit_q;
    ctrl_val[BIT_PHY_ENH]     = phy_enh_q;
    ctrl_val[BIT_LINK_POWER]  = link_power_q;
    ctrl_val[BIT_POSTED_WR]   = posted_wr_q;
    ctrl_val[BIT_LINK_ON]     = link_on_q;
    ctrl_val[BIT_SW_RESET]    = sw_reset_q;
  end

  always_comb begin
    rd_data = 32'h00000000;
    mapped  = 1'b1;
    if (is_phy) begin
      rd_data = phy_mem_q[phy_idx];
    end else begin
      unique case (PADDR_I)
        OFS_CTRL_SET, OFS_CTRL_CLR: begin
          rd_data = ctrl_val;
        end
        OFS_SELF_ID: begin
          rd_data = {self_id_q, 11'h000};
        end
        OFS_EVENT_SET, OFS_EVENT_CLR: begin
          rd_data[BIT_EV_TARDY] = ev_tardy_q;
        end
        OFS_MISC_CFG: begin
          rd_data[BIT_ABORT_DIS] = abort_dis_q;
        end
        default: begin
          mapped = 1'b0;
        end
      endcase
    end
  end

  // PHY-domain words answer on a sampled link edge, or at once while the link clock is flagged stopped
  assign phy_ok = ~is_phy | lclk_rise | stopped_q;

  // ******************************************************************
  // APB answer: one wait state, longer for the PHY domain
  // ******************************************************************
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else if (access & ~pready_q & phy_ok) begin
      pready_q  <= 1'b1;
      pslverr_q <= ~mapped;
      prdata_q  <= PWRITE_I ? 32'h00000000 : rd_data;
      if (is_phy & stopped_q & ~lclk_rise) begin
        pslverr_q <= ~abort_dis_q;
        prdata_q  <= abort_dis_q ? RD_ALL_ONES : 32'h00000000;
      end
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end
  end

  // ******************************************************************
  // Control set/clear bits
  // ******************************************************************
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      no_swap_q    <= RST_CTRL_BIT;
      tardy_en_q   <= RST_CTRL_BIT;
      link_power_q <= RST_CTRL_BIT;
    end else if (sw_reset_q) begin
      no_swap_q    <= RST_CTRL_BIT;
      tardy_en_q   <= RST_CTRL_BIT;
      link_power_q <= RST_CTRL_BIT;
    end else if (wr_set) begin
      no_swap_q    <= no_swap_q    | PWDATA_I[BIT_NO_SWAP];
      tardy_en_q   <= tardy_en_q   | PWDATA_I[BIT_TARDY_EN];
      link_power_q <= link_power_q | PWDATA_I[BIT_LINK_POWER];
    end else if (wr_clr) begin
      no_swap_q    <= no_swap_q    & ~PWDATA_I[BIT_NO_SWAP];
      tardy_en_q   <= tardy_en_q   & ~PWDATA_I[BIT_TARDY_EN];
      link_power_q <= link_power_q & ~PWDATA_I[BIT_LINK_POWER];
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      link_on_q <= RST_CTRL_BIT;
    end else if (sw_reset_q) begin
      link_on_q <= RST_CTRL_BIT;
    end else if (wr_set & PWDATA_I[BIT_LINK_ON]) begin
      link_on_q <= 1'b1;
    end else if (wr_clr & PWDATA_I[BIT_LINK_ON]) begin
      link_on_q <= 1'b0;
    end
  end

  // Ignored while the link runs, so DMA never sees a mid-stream change
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      posted_wr_q <= RST_CTRL_BIT;
    end else if (sw_reset_q) begin
      posted_wr_q <= RST_CTRL_BIT;
    end else if (~link_on_q & wr_set & PWDATA_I[BIT_POSTED_WR]) begin
      posted_wr_q <= 1'b1;
    end else if (~link_on_q & wr_clr & PWDATA_I[BIT_POSTED_WR]) begin
      posted_wr_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      phy_enh_q <= RST_CTRL_BIT;
    end else if (sw_reset_q) begin
      phy_enh_q <= RST_CTRL_BIT;
    end else if (wr_set & PWDATA_I[BIT_PHY_ENH] & permit_q & link_on_q) begin
      phy_enh_q <= 1'b1;
    end else if (wr_clr & PWDATA_I[BIT_PHY_ENH]) begin
      phy_enh_q <= 1'b0;
    end
  end

  // Soft reset leaves the permit alone; global reset sets it and only an EEPROM load can clear it
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      permit_q <= RST_PERMIT;
    end else if (EEPROM_LOAD_I) begin
      permit_q <= EEPROM_PERMIT_I;
    end
  end

  // ******************************************************************
  // Soft reset sequencing
  // ******************************************************************
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sw_reset_q <= 1'b0;
      swr_cnt_q  <= 8'h00;
    end else if (sw_reset_q) begin
      if (swr_cnt_q == 8'(SWR_LEN - 1)) begin
        sw_reset_q <= 1'b0;
        swr_cnt_q  <= 8'h00;
      end else begin
        swr_cnt_q <= swr_cnt_q + 8'h01;
      end
    end else if (wr_set & PWDATA_I[BIT_SW_RESET]) begin
      sw_reset_q <= 1'b1;
    end
  end

  // ******************************************************************
  // Self-ID base and misc configuration
  // ******************************************************************
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      self_id_q <= RST_SELF_ID;
    end else if (sw_reset_q) begin
      self_id_q <= RST_SELF_ID;
    end else if (wr_commit & (PADDR_I == OFS_SELF_ID)) begin
      self_id_q <= PWDATA_I[31:SELF_ID_LSB];
    end
  end

  // Configuration space: soft reset does not touch it
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      abort_dis_q <= 1'b0;
    end else if (wr_commit & (PADDR_I == OFS_MISC_CFG)) begin
      abort_dis_q <= PWDATA_I[BIT_ABORT_DIS];
    end
  end

  // ******************************************************************
  // PHY-clock-domain words
  // ******************************************************************
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      for (int i = 0; i < PHY_WORDS; i++) begin
        phy_mem_q[i] <= 32'h00000000;
      end
    end else if (sw_reset_q) begin
      for (int i = 0; i < PHY_WORDS; i++) begin
        phy_mem_q[i] <= 32'h00000000;
      end
    end else if (wr_commit & is_phy & ~stopped_q) begin
      phy_mem_q[phy_idx] <= PWDATA_I;
    end
  end

  // ******************************************************************
  // Tardy acknowledge and its event
  // ******************************************************************
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ack_tardy_q <= 1'b0;
    end else begin
      ack_tardy_q <= ASYNC_REQ_I & tardy_en_q & link_on_q
                     & ~sw_reset_q;
    end
  end

  // New tardy answer beats a clear in the same cycle
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ev_tardy_q <= 1'b0;
    end else if (ev_set_hit) begin
      ev_tardy_q <= 1'b1;
    end else if (sw_reset_q) begin
      ev_tardy_q <= 1'b0;
    end else if (wr_commit & PWDATA_I[BIT_EV_TARDY]
                 & (PADDR_I == OFS_EVENT_SET)) begin
      ev_tardy_q <= 1'b1;
    end else if (wr_commit & PWDATA_I[BIT_EV_TARDY]
                 & (PADDR_I == OFS_EVENT_CLR)) begin
      ev_tardy_q <= 1'b0;
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************
  assign PRDATA_O           = prdata_q;
  assign PREADY_O           = pready_q;
  assign PSLVERR_O          = pslverr_q;
  assign ACK_TARDY_O        = ack_tardy_q;
  assign NO_BYTE_SWAP_O     = no_swap_q;
  assign PHY_ENHANCE_O      = phy_enh_q;
  assign LINK_POWER_O       = link_power_q;
  assign POSTED_WRITE_O     = posted_wr_q;
  assign LINK_ON_O          = link_on_q;
  assign SOFT_RESET_O       = sw_reset_q;
  assign LINK_CLK_STOPPED_O = stopped_q;
  assign SELF_ID_BASE_O     = {self_id_q, 11'h000};

endmodule

`default_nettype wire
